/* verilog/upec_pkg.sv */
// Constants for the UART packet error check block
package upec_pkg;

  // Code polynomial, Koopman form with implicit +1 term, and bit-reflected form for LSB-first shifting
  localparam logic [7:0] CRC_POLY_NORMAL    = 8'ha6;
  localparam logic [7:0] CRC_POLY_REFLECTED = 8'hb2;
  localparam logic [7:0] CRC_INIT           = 8'h00;
  localparam int         BYTE_BITS          = 8;

  // Error-detection figures of the combined link checks
  localparam int HAMMING_DISTANCE = 6;
  localparam int MAX_PACKET_BITS  = 247;

  // Received byte kinds as tagged by the character receiver
  localparam logic [1:0] KIND_DATA  = 2'h0;
  localparam logic [1:0] KIND_ALIVE = 2'h1;
  localparam logic [1:0] KIND_CODE  = 2'h2;

  // Path indices
  localparam int PATH_UP   = 0;
  localparam int PATH_DOWN = 1;

  // APB register byte offsets
  localparam logic [7:0] ADDR_CONFIG        = 8'h00;
  localparam logic [7:0] ADDR_FIRST_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_SECOND_STATUS = 8'h08;
  localparam logic [7:0] ADDR_DEVADDR       = 8'h0c;
  localparam logic [7:0] ADDR_LINK          = 8'h10;
  localparam logic [7:0] ADDR_TXCODE        = 8'h14;
  localparam logic [7:0] ADDR_LASTRX        = 8'h18;

  // Field positions
  localparam int CFG_DUAL_UART_BIT    = 0;
  localparam int CFG_SINGLE_ENDED_BIT = 1;
  localparam int ST1_SUMMARY_BIT      = 0;
  localparam int ST2_UP_BIT           = 0;
  localparam int ST2_DOWN_BIT         = 1;
  localparam int LINK_BAUD_BIT        = 0;
  localparam int LINK_RXMODE_BIT      = 1;

  // Reset values
  localparam logic [1:0] CONFIG_RESET  = 2'h0;
  localparam logic [7:0] DEVADDR_RESET = 8'h00;

endpackage

/* verilog/upec_crc8.sv */
// Byte-wide CRC-8 engine, LSB first, right shifting
`timescale 1ns/1ps

module upec_crc8
  import upec_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic       feed,
  input  wire logic [7:0] data,
  output logic      [7:0] crc
);

  logic [7:0] next_crc;

  // Fold one byte in, eight right shifts with the reflected polynomial
  always_comb begin
    next_crc = crc ^ data;
    for (int i = 0; i < BYTE_BITS; i++) begin
      if (next_crc[0]) begin
        next_crc = (next_crc >> 1) ^ CRC_POLY_REFLECTED;
      end else begin
        next_crc = next_crc >> 1;
      end
    end
  end

  // Remainder register; clear wins so each packet starts from zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crc <= CRC_INIT;
    end else if (clear) begin
      crc <= CRC_INIT;
    end else if (feed) begin
      crc <= next_crc;
    end
  end

  a_crc_clears: assert property (@(posedge pclk) disable iff (!presetn)
    clear |=> crc == CRC_INIT)
    else $error("crc engine not cleared");

  a_crc_holds: assert property (@(posedge pclk) disable iff (!presetn)
    !clear && !feed |=> crc == $past(crc))
    else $error("crc engine changed without feed");

endmodule

/* verilog/upec_top.sv */
// UART packet error check block with APB register access
//
// Local design decisions: the APB slave port and the address map.
`timescale 1ns/1ps

// Summary of operation
// - Any reset clears device address to zero and marks baud and receive modes undetected.
// - Each packet is judged on Manchester, parity, framing and packet code checks.
// - Combined checks give Hamming distance 6 for packets up to 247 bits.
// - Read-all and read-single commands carry a data-check byte covered by the code.
// - Bad code sets the path flag in status two and summary in status one.
// - In single-UART mode every code error is reported on the up-path flag.
// - In dual-UART mode up and down errors set their own path flags.
// - Written commands are accepted only when received code equals computed remainder.
// - Code is CRC-8 with polynomial x^8+x^6+x^3+x^2+1, value 0xA6.
// - Single-ended receive mode leaves transmitter behaviour unchanged.
// - Each computation starts from a cleared engine, fed LSB first, byte order.
// - Code covers every packet byte before it, except alive-counter and code bytes.
// - Bytewise right shift uses reflected constant 0xB2 when the low bit is one.
module upec_top
  import upec_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        up_rx_start,
  input  wire logic        up_rx_valid,
  input  wire logic [7:0]  up_rx_byte,
  input  wire logic [1:0]  up_rx_kind,
  input  wire logic        up_rx_char_error,
  output logic             up_cmd_accept,
  output logic             up_cmd_reject,
  input  wire logic        down_rx_start,
  input  wire logic        down_rx_valid,
  input  wire logic [7:0]  down_rx_byte,
  input  wire logic [1:0]  down_rx_kind,
  input  wire logic        down_rx_char_error,
  output logic             down_cmd_accept,
  output logic             down_cmd_reject,
  input  wire logic        baud_detect_done,
  input  wire logic        tx_start,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_byte,
  output logic      [7:0]  tx_code,
  output logic             dual_uart_mode,
  output logic             lower_rx_single_ended
);

  // Per-path views of the receive ports
  logic [1:0]       rx_start;
  logic [1:0]       rx_valid;
  logic [1:0][7:0]  rx_byte;
  logic [1:0][1:0]  rx_kind;
  logic [1:0]       rx_char_error;
  logic [1:0][7:0]  rx_crc;
  logic [1:0]       pkt_char_bad;
  logic [1:0]       cmd_accept;
  logic [1:0]       cmd_reject;
  logic [1:0]       code_mismatch;
  logic [1:0][7:0]  last_rx_code;

  // Register state
  logic [1:0]       config_bits;
  logic             packet_code_error_summary;
  logic             up_path_code_error;
  logic             down_path_code_error;
  logic [7:0]       device_address;
  logic             baud_detected;
  logic             rx_mode_detected;

  // Bus decode
  logic             bus_setup;
  logic             bus_write;
  logic             addr_hit;
  logic [31:0]      next_prdata;
  logic             up_err_event;
  logic             down_err_event;
  logic             clr_summary;
  logic             clr_up;
  logic             clr_down;

  assign rx_start      = {down_rx_start, up_rx_start};
  assign rx_valid      = {down_rx_valid, up_rx_valid};
  assign rx_byte       = {down_rx_byte, up_rx_byte};
  assign rx_kind       = {down_rx_kind, up_rx_kind};
  assign rx_char_error = {down_rx_char_error, up_rx_char_error};

  assign up_cmd_accept   = cmd_accept[PATH_UP];
  assign up_cmd_reject   = cmd_reject[PATH_UP];
  assign down_cmd_accept = cmd_accept[PATH_DOWN];
  assign down_cmd_reject = cmd_reject[PATH_DOWN];

  assign dual_uart_mode        = config_bits[CFG_DUAL_UART_BIT];
  assign lower_rx_single_ended = config_bits[CFG_SINGLE_ENDED_BIT];

  // One checker per receive path: engine, character error memory, verdict
  for (genvar p = 0; p < 2; p++) begin : g_path
    logic feed_byte;
    logic code_byte;

    // Alive-counter and code bytes stay out of the remainder
    assign feed_byte = rx_valid[p] && !rx_start[p] && (rx_kind[p] == KIND_DATA);
    assign code_byte = rx_valid[p] && (rx_kind[p] == KIND_CODE);

    upec_crc8 u_crc (
      .pclk    (pclk),
      .presetn (presetn),
      .clear   (rx_start[p]),
      .feed    (feed_byte),
      .data    (rx_byte[p]),
      .crc     (rx_crc[p])
    );

    // Any Manchester, parity or framing fault in the packet is remembered
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pkt_char_bad[p] <= 1'b0;
      end else if (rx_start[p]) begin
        pkt_char_bad[p] <= 1'b0;
      end else if (rx_valid[p] && rx_char_error[p]) begin
        pkt_char_bad[p] <= 1'b1;
      end
    end

    assign code_mismatch[p] = code_byte && (rx_byte[p] != rx_crc[p]);

    // Verdict on the code byte: accept only with a clean packet and equal code
    always_comb begin
      cmd_accept[p] = code_byte && !code_mismatch[p] && !pkt_char_bad[p] && !rx_char_error[p];
      cmd_reject[p] = code_byte && !cmd_accept[p];
    end

    // Last received code byte, kept for software
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        last_rx_code[p] <= CRC_INIT;
      end else if (code_byte) begin
        last_rx_code[p] <= rx_byte[p];
      end
    end

    a_accept_needs_match: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_accept[p] |-> rx_byte[p] == rx_crc[p] && !pkt_char_bad[p])
      else $error("command accepted with bad code");

    a_accept_reject_excl: assert property (@(posedge pclk) disable iff (!presetn)
      !(cmd_accept[p] && cmd_reject[p]))
      else $error("accept and reject together");
  end

  // Outgoing code over transmitted bytes; independent of receive mode
  upec_crc8 u_tx_crc (
    .pclk    (pclk),
    .presetn (presetn),
    .clear   (tx_start),
    .feed    (tx_valid && !tx_start),
    .data    (tx_byte),
    .crc     (tx_code)
  );

  // Route code errors to path flags by UART configuration
  always_comb begin
    if (dual_uart_mode) begin
      up_err_event   = code_mismatch[PATH_UP];
      down_err_event = code_mismatch[PATH_DOWN];
    end else begin
      up_err_event   = code_mismatch[PATH_UP] || code_mismatch[PATH_DOWN];
      down_err_event = 1'b0;
    end
  end

  // APB handshake: zero wait states, error on unmapped offsets
  assign bus_setup = psel && !penable;
  assign bus_write = psel && penable && pwrite;
  assign pready    = 1'b1;
  assign addr_hit  = (paddr == ADDR_CONFIG) || (paddr == ADDR_FIRST_STATUS) || (paddr == ADDR_SECOND_STATUS) ||
                     (paddr == ADDR_DEVADDR) || (paddr == ADDR_LINK) || (paddr == ADDR_TXCODE) ||
                     (paddr == ADDR_LASTRX);
  assign pslverr   = psel && penable && !addr_hit;

  // Write-one-to-clear strobes for the sticky flags
  assign clr_summary = bus_write && (paddr == ADDR_FIRST_STATUS) && pwdata[ST1_SUMMARY_BIT];
  assign clr_up      = bus_write && (paddr == ADDR_SECOND_STATUS) && pwdata[ST2_UP_BIT];
  assign clr_down    = bus_write && (paddr == ADDR_SECOND_STATUS) && pwdata[ST2_DOWN_BIT];

  // Configuration register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_bits <= CONFIG_RESET;
    end else if (bus_write && paddr == ADDR_CONFIG) begin
      config_bits <= pwdata[1:0];
    end
  end

  // Sticky packet code flags; a new error wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      up_path_code_error        <= 1'b0;
      down_path_code_error      <= 1'b0;
      packet_code_error_summary <= 1'b0;
    end else begin
      if (up_err_event) begin
        up_path_code_error <= 1'b1;
      end else if (clr_up) begin
        up_path_code_error <= 1'b0;
      end
      if (down_err_event) begin
        down_path_code_error <= 1'b1;
      end else if (clr_down) begin
        down_path_code_error <= 1'b0;
      end
      if (up_err_event || down_err_event) begin
        packet_code_error_summary <= 1'b1;
      end else if (clr_summary) begin
        packet_code_error_summary <= 1'b0;
      end
    end
  end

  // Chain address, zero after every reset until assigned again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      device_address <= DEVADDR_RESET;
    end else if (bus_write && paddr == ADDR_DEVADDR) begin
      device_address <= pwdata[7:0];
    end
  end

  // Baud and receive mode detection state, undetected after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      baud_detected    <= 1'b0;
      rx_mode_detected <= 1'b0;
    end else if (baud_detect_done) begin
      baud_detected    <= 1'b1;
      rx_mode_detected <= 1'b1;
    end
  end

  // Read mux
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      ADDR_CONFIG: begin
        next_prdata[1:0] = config_bits;
      end
      ADDR_FIRST_STATUS: begin
        next_prdata[ST1_SUMMARY_BIT] = packet_code_error_summary;
      end
      ADDR_SECOND_STATUS: begin
        next_prdata[ST2_UP_BIT]   = up_path_code_error;
        next_prdata[ST2_DOWN_BIT] = down_path_code_error;
      end
      ADDR_DEVADDR: begin
        next_prdata[7:0] = device_address;
      end
      ADDR_LINK: begin
        next_prdata[LINK_BAUD_BIT]   = baud_detected;
        next_prdata[LINK_RXMODE_BIT] = rx_mode_detected;
      end
      ADDR_TXCODE: begin
        next_prdata[7:0] = tx_code;
      end
      ADDR_LASTRX: begin
        next_prdata[15:0] = {last_rx_code[PATH_DOWN], last_rx_code[PATH_UP]};
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  // Read data captured in the setup cycle, stable through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (bus_setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

  // Checks on the flags and reset state
  a_up_flag_sets: assert property (@(posedge pclk) disable iff (!presetn)
    code_mismatch[PATH_UP] |=> up_path_code_error && packet_code_error_summary)
    else $error("up path error not flagged");

  a_single_maps_up: assert property (@(posedge pclk) disable iff (!presetn)
    !dual_uart_mode && code_mismatch[PATH_DOWN] |=> up_path_code_error && !$rose(down_path_code_error))
    else $error("single uart error not on up flag");

  a_dual_down_flag: assert property (@(posedge pclk) disable iff (!presetn)
    dual_uart_mode && code_mismatch[PATH_DOWN] |=> down_path_code_error)
    else $error("down path error not flagged");

  a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    up_path_code_error && !clr_up |=> up_path_code_error)
    else $error("up flag dropped without clear");

  a_summary_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    packet_code_error_summary && !clr_summary |=> packet_code_error_summary)
    else $error("summary flag dropped without clear");

  a_reset_address: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> device_address == DEVADDR_RESET && !baud_detected)
    else $error("address or baud state not cleared after reset");

  a_reject_on_mismatch: assert property (@(posedge pclk) disable iff (!presetn)
    code_mismatch[PATH_UP] |-> up_cmd_reject && !up_cmd_accept)
    else $error("mismatched code not rejected");

  a_read_data: assert property (@(posedge pclk) disable iff (!presetn)
    bus_setup && !pwrite && paddr == ADDR_SECOND_STATUS ##1 psel && penable
      |-> prdata[ST2_UP_BIT] == $past(up_path_code_error))
    else $error("status read data wrong");

  a_down_reject: assert property (@(posedge pclk) disable iff (!presetn)
    code_mismatch[PATH_DOWN] |-> down_cmd_reject && !down_cmd_accept)
    else $error("mismatched down code not rejected");

  a_char_fault_reject: assert property (@(posedge pclk) disable iff (!presetn)
    up_rx_valid && up_rx_kind == KIND_CODE && up_rx_char_error |-> up_cmd_reject)
    else $error("character fault on code byte not rejected");

  a_clear_drops_flag: assert property (@(posedge pclk) disable iff (!presetn)
    clr_up && !up_err_event |=> !up_path_code_error)
    else $error("up flag not cleared by software");

  a_single_down_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    !dual_uart_mode |=> !$rose(down_path_code_error))
    else $error("down flag set in single uart mode");

  c_up_accept: cover property (@(posedge pclk) disable iff (!presetn) up_cmd_accept);
  c_up_reject: cover property (@(posedge pclk) disable iff (!presetn) code_mismatch[PATH_UP]);
  c_down_dual: cover property (@(posedge pclk) disable iff (!presetn) dual_uart_mode && down_cmd_reject);
  c_set_clear: cover property (@(posedge pclk) disable iff (!presetn) up_err_event && clr_up);

endmodule

/* tb/upec_host_model.sv */
// Host-side link model that frames packets and appends their code byte
`timescale 1ns/1ps

module upec_host_model
  import upec_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic [1:0] accept,
  input  wire logic [1:0] reject,
  output logic      [1:0] start,
  output logic      [1:0] valid,
  output logic      [7:0] rx_byte,
  output logic      [1:0] kind,
  output logic            char_error
);
  logic [7:0] pkt [0:7];

  // Idle link levels
  initial begin
    start      = 2'h0;
    valid      = 2'h0;
    rx_byte    = 8'h5a;
    kind       = 2'h0;
    char_error = 1'b0;
  end

  // One byte through the right-shifting engine, LSB first
  function automatic logic [7:0] crc_byte(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < BYTE_BITS; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY_REFLECTED) : (r >> 1);
    end
    return r;
  endfunction

  // Send pkt[0..n-1]; byte al goes as alive counter; bad spoils the code
  task automatic send(input int path, input int n, input bit bad, input int al, input bit ce,
                      output logic acc, output logic rej);
    logic [7:0] c;
    c = CRC_INIT;
    @(posedge pclk);
    start[path] <= 1'b1;
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      start        <= 2'h0;
      valid[path]  <= 1'b1;
      rx_byte      <= pkt[i];
      kind         <= (i == al) ? KIND_ALIVE : KIND_DATA;
      if (i != al) begin
        c = crc_byte(c, pkt[i]);
      end
    end
    @(posedge pclk);
    start       <= 2'h0;
    valid[path] <= 1'b1;
    kind        <= KIND_CODE;
    rx_byte     <= bad ? (c ^ 8'h01) : c;
    char_error  <= ce;
    @(posedge pclk);
    acc = accept[path];
    rej = reject[path];
    valid      <= 2'h0;
    char_error <= 1'b0;
    rx_byte    <= ~rx_byte;
  endtask
endmodule

/* tb/testbench.sv */
// Self-checking bench for the packet error check block
`timescale 1ns/1ps

module testbench
  import upec_pkg::*;
;
  logic        pclk, presetn, psel, penable, pwrite, baud_detect_done, tx_start, tx_valid;
  logic        pready, pslverr, dual_uart_mode, lower_rx_single_ended, char_error;
  logic [7:0]  paddr, tx_byte, tx_code, rx_byte;
  logic [31:0] pwdata, prdata;
  logic [1:0]  start, valid, kind, accept, reject;
  logic [15:0] lfsr;
  int          n_mismatch, checks, cyc;

  upec_top dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .up_rx_start(start[0]), .up_rx_valid(valid[0]), .up_rx_byte(rx_byte), .up_rx_kind(kind),
    .up_rx_char_error(char_error), .up_cmd_accept(accept[0]), .up_cmd_reject(reject[0]),
    .down_rx_start(start[1]), .down_rx_valid(valid[1]), .down_rx_byte(rx_byte), .down_rx_kind(kind),
    .down_rx_char_error(char_error), .down_cmd_accept(accept[1]), .down_cmd_reject(reject[1]),
    .baud_detect_done(baud_detect_done), .tx_start(tx_start), .tx_valid(tx_valid), .tx_byte(tx_byte),
    .tx_code(tx_code), .dual_uart_mode(dual_uart_mode), .lower_rx_single_ended(lower_rx_single_ended)
  );

  upec_host_model host (
    .pclk(pclk), .accept(accept), .reject(reject), .start(start), .valid(valid),
    .rx_byte(rx_byte), .kind(kind), .char_error(char_error)
  );

  // Clock at 100 ns
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  // Hang guard
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  function automatic logic [7:0] rnd_byte();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input bit wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    int          p, n, al;
    bit          bad, ce;
    logic        acc, rej, err;
    logic [7:0]  c, b;
    logic [31:0] rd, st2;
    {psel, penable, pwrite, presetn, baud_detect_done, tx_start, tx_valid} = '0;
    {paddr, pwdata, tx_byte} = '0;
    lfsr = 16'h0049;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Every register reads zero after reset
    for (int a = 0; a <= 24; a += 4) begin
      apb(1'b0, 8'(a), 32'h0000_0000, rd, err);
      check("reset value", rd, 32'h0000_0000);
    end
    check("tx code reset", tx_code, 8'h00);
    apb(1'b0, 8'h1c, 32'h0000_0000, rd, err);
    check("unmapped read error", err, 1);
    check("unmapped read data", rd, 32'h0000_0000);
    apb(1'b1, 8'h40, 32'hffff_ffff, rd, err);
    check("unmapped write error", err, 1);
    b = rnd_byte();
    apb(1'b1, ADDR_DEVADDR, {24'h00_0000, b}, rd, err);
    apb(1'b0, ADDR_DEVADDR, 32'h0000_0000, rd, err);
    check("address readback", rd, {24'h00_0000, b});
    @(posedge pclk);
    baud_detect_done <= 1'b1;
    @(posedge pclk);
    baud_detect_done <= 1'b0;
    apb(1'b0, ADDR_LINK, 32'h0000_0000, rd, err);
    check("link detected", rd, 32'h0000_0003);
    // All configuration modes
    for (int m = 0; m < 4; m++) begin
      apb(1'b1, ADDR_CONFIG, 32'(m), rd, err);
      apb(1'b0, ADDR_CONFIG, 32'h0000_0000, rd, err);
      check("config readback", rd, 32'(m));
      check("dual mode", dual_uart_mode, m % 2);
      check("single ended", lower_rx_single_ended, m / 2);
    end
    // Random packets in single then dual UART mode
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, ADDR_CONFIG, 32'(m), rd, err);
      st2 = 32'h0000_0000;
      for (int k = 0; k < 10; k++) begin
        p = (k < 4) ? k / 2 : int'(rnd_byte() & 8'h01);
        n = 1 + int'(rnd_byte() & 8'h07);
        al = (k % 3 == 2) ? n - 1 : -1;
        for (int i = 0; i < 8; i++) host.pkt[i] = rnd_byte();
        bad = (k % 2 == 1);
        ce = (k == 6);
        if (bad) st2 = st2 | ((m == 1) ? (32'h1 << p) : 32'h1);
        host.send(p, n, bad, al, ce, acc, rej);
        check("accept", acc, !(bad || ce));
        check("reject", rej, bad || ce);
        apb(1'b0, ADDR_SECOND_STATUS, 32'h0000_0000, rd, err);
        check("path flags", rd, st2);
        apb(1'b0, ADDR_FIRST_STATUS, 32'h0000_0000, rd, err);
        check("summary flag", rd, st2 != 0);
      end
      apb(1'b1, ADDR_FIRST_STATUS, 32'h0000_0001, rd, err);
      apb(1'b0, ADDR_FIRST_STATUS, 32'h0000_0000, rd, err);
      check("summary cleared", rd, 32'h0000_0000);
      apb(1'b0, ADDR_SECOND_STATUS, 32'h0000_0000, rd, err);
      check("path flags kept", rd, st2);
      apb(1'b1, ADDR_SECOND_STATUS, 32'h0000_0003, rd, err);
      apb(1'b0, ADDR_SECOND_STATUS, 32'h0000_0000, rd, err);
      check("path flags cleared", rd, 32'h0000_0000);
    end
    // Corner: code error and software clear of its flag on one edge, the error wins
    c = host.crc_byte(host.crc_byte(CRC_INIT, host.pkt[0]), host.pkt[1]);
    fork
      host.send(PATH_UP, 2, 1'b1, -1, 1'b0, acc, rej);
      begin
        repeat (2) @(posedge pclk);
        apb(1'b1, ADDR_SECOND_STATUS, 32'h0000_0001, rd, err);
      end
    join
    check("corner reject", rej, 1);
    apb(1'b0, ADDR_SECOND_STATUS, 32'h0000_0000, rd, err);
    check("flag set over clear", rd, 32'h0000_0001);
    apb(1'b0, ADDR_LASTRX, 32'h0000_0000, rd, err);
    check("last up code", rd[7:0], c ^ 8'h01);
    // Outgoing code over random bytes
    @(posedge pclk);
    tx_start <= 1'b1;
    c = CRC_INIT;
    for (int i = 0; i < 5; i++) begin
      @(posedge pclk);
      b = rnd_byte();
      tx_start <= 1'b0;
      tx_valid <= 1'b1;
      tx_byte  <= b;
      c = host.crc_byte(c, b);
    end
    @(posedge pclk);
    tx_valid <= 1'b0;
    @(posedge pclk);
    check("tx code", tx_code, c);
    apb(1'b0, ADDR_TXCODE, 32'h0000_0000, rd, err);
    check("tx code register", rd, {24'h00_0000, c});
    // Second reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ADDR_DEVADDR, 32'h0000_0000, rd, err);
    check("address after reset", rd, 32'h0000_0000);
    apb(1'b0, ADDR_LINK, 32'h0000_0000, rd, err);
    check("link after reset", rd, 32'h0000_0000);
    apb(1'b0, ADDR_SECOND_STATUS, 32'h0000_0000, rd, err);
    check("flags after reset", rd, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
